// ---- core/btpl_core.sv ----
`timescale 1ns/1ps
// transaction policy and downstream lock control of the bridge
module btpl_core (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // pci target decode
  input wire logic PCI_TGT_VALID,
  input wire logic [3:0] PCI_TGT_CMD,
  input wire logic PCI_TGT_DEVID_MSG,
  output logic PCI_TGT_CLAIM,
  output logic PCI_TGT_RETRY,
  output logic PCI_TGT_MABORT,
  // pci master engine
  input wire logic PCI_MST_REQ,
  input wire logic [3:0] PCI_MST_CMD,
  input wire logic PCI_MST_BUSY,
  input wire logic PCI_MST_DONE,
  input wire logic PCI_MST_TRDY,
  input wire logic PCI_MST_ABORT,
  output logic PCI_MST_GO,
  // locked read sequencing
  input wire logic DN_AHEAD_IDLE,
  output logic LK_RD_START,
  output logic LK_CPL_ERR,
  output logic LOCK_TGT,
  output logic LOCK_FULL,
  // bus lock pin
  input wire logic BUS_LOCK_PIN_N_I,
  output logic BUS_LOCK_PIN_N_O,
  output logic BUS_LOCK_PIN_N_OE,
  // received tlp
  input wire logic RX_VALID,
  input wire btpl_pkg::btpl_tlp_t RX_TYPE,
  input wire logic [7:0] RX_MSG_CODE,
  input wire logic [1:0] RX_SPL_SCALE,
  input wire logic [7:0] RX_SPL_VALUE,
  output logic RX_ACCEPT,
  output logic RX_UR,
  output logic RX_MALF,
  output logic RX_DROP,
  // slot power fields
  output logic [1:0] SLOT_PWR_SCALE,
  output logic [7:0] SLOT_PWR_VALUE,
  // transmit tlp
  input wire logic TX_VALID,
  input wire btpl_pkg::btpl_tlp_t TX_TYPE,
  output logic TX_GO,
  // ordering
  input wire logic ORD_ENQ_POSTED,
  input wire logic ORD_ISS_POSTED,
  input wire btpl_pkg::btpl_ord_t ORD_CLASS,
  input wire logic ORD_RO,
  input wire logic [btpl_pkg::STAMP_W-1:0] ORD_STAMP_IN,
  output logic [btpl_pkg::STAMP_W-1:0] ORD_STAMP,
  output logic ORD_PASS_OK,
  // interrupt and pme pins, upstream messages
  input wire logic [3:0] PCI_INT_N,
  input wire logic PM_EVENT_IN_N,
  input wire logic UP_MSG_READY,
  output logic UP_MSG_VALID,
  output logic [7:0] UP_MSG_CODE
);
  import btpl_pkg::*;

  btpl_lock_t lock_st_ff;
  btpl_lock_t nxt_lock_st;
  logic rd_pend_ff;
  logic rd_act_ff;
  logic drive_ff;
  logic cpl_err_ff;
  logic [1:0] scale_ff;
  logic [7:0] value_ff;
  logic pin_s1_ff;
  logic pin_s2_ff;

  wire st_idle = (lock_st_ff == LK_IDLE);
  wire st_tgt = (lock_st_ff == LK_TGT);
  wire st_full = (lock_st_ff == LK_FULL);

  // pci command policy; the bus lock pin is never looked at here
  assign PCI_TGT_CLAIM = PCI_TGT_VALID && TGT_CMD_MASK[PCI_TGT_CMD] && !PCI_TGT_DEVID_MSG;
  assign PCI_TGT_MABORT = PCI_TGT_VALID && !PCI_TGT_CLAIM;
  assign PCI_TGT_RETRY = PCI_TGT_CLAIM && st_full;
  assign PCI_MST_GO = PCI_MST_REQ && MST_CMD_MASK[PCI_MST_CMD];

  // message code classes
  wire rx_msg = (RX_TYPE == TLP_MSG) || (RX_TYPE == TLP_MSGD);
  wire mc_unlock = rx_msg && (RX_MSG_CODE == MC_UNLOCK);
  wire mc_spl = (RX_TYPE == TLP_MSGD) && (RX_MSG_CODE == MC_SPL);
  wire mc_intx = rx_msg && (RX_MSG_CODE[7:3] == MC_INTX[7:3]);
  wire mc_err = rx_msg && ((RX_MSG_CODE == MC_ERR_COR) || (RX_MSG_CODE == MC_ERR_NF)
    || (RX_MSG_CODE == MC_ERR_F));
  wire mc_ign = rx_msg && (RX_MSG_CODE >= MC_IGN_LO) && (RX_MSG_CODE <= MC_IGN_HI);
  wire mc_v0 = rx_msg && (RX_MSG_CODE == MC_VEND0);
  wire mc_v1 = rx_msg && (RX_MSG_CODE == MC_VEND1);

  // received type classes
  wire rx_lkcpl = (RX_TYPE == TLP_CPLLK) || (RX_TYPE == TLP_CPLDLK);
  wire rx_cpl = (RX_TYPE == TLP_CPL) || (RX_TYPE == TLP_CPLD);
  wire rx_mem = (RX_TYPE == TLP_MRD) || (RX_TYPE == TLP_MWR) || (RX_TYPE == TLP_MRDLK);
  wire rx_lkrd = RX_VALID && (RX_TYPE == TLP_MRDLK);

  // base verdicts, before the lock state overrides them
  wire base_malf = mc_intx;
  wire base_ur = rx_lkcpl || mc_err || mc_v0;
  wire base_drop = mc_ign || mc_v1;
  // full-lock turns away every non-memory request but the unlock itself
  wire full_ur = st_full && !rx_mem && !rx_cpl && !rx_lkcpl && !mc_unlock;
  wire v_ur = st_tgt || full_ur || base_ur;
  wire v_malf = !v_ur && base_malf;
  wire v_drop = !v_ur && !v_malf && base_drop;

  // one verdict per received tlp
  assign RX_UR = RX_VALID && v_ur;
  assign RX_MALF = RX_VALID && v_malf;
  assign RX_DROP = RX_VALID && v_drop;
  assign RX_ACCEPT = RX_VALID && !v_ur && !v_malf && !v_drop;
  wire spl_take = RX_ACCEPT && mc_spl;
  wire unlock_take = RX_ACCEPT && mc_unlock && st_full;

  // transmit policy: locked completions only while a locked read is served
  wire tx_req = (TX_TYPE == TLP_MRD) || (TX_TYPE == TLP_MWR) || (TX_TYPE == TLP_IORD)
    || (TX_TYPE == TLP_IOWR) || (TX_TYPE == TLP_MSG);
  wire tx_cpl = (TX_TYPE == TLP_CPL) || (TX_TYPE == TLP_CPLD);
  wire tx_lkcpl = (TX_TYPE == TLP_CPLLK) || (TX_TYPE == TLP_CPLDLK);
  // locked reads, config requests and MsgD never leave on the link
  assign TX_GO = TX_VALID && ((tx_req && !st_full) || tx_cpl || (tx_lkcpl && !st_idle));

  // locked read launch: queue ahead drained and nobody else holds the bus lock
  wire bus_free = pin_s2_ff;
  assign LK_RD_START = st_tgt && rd_pend_ff && DN_AHEAD_IDLE && bus_free;
  wire rd_end = rd_act_ff && PCI_MST_DONE;
  // lock needs our lock pin driven and a target that answered with TRDY
  wire rd_ok = rd_end && PCI_MST_TRDY && !PCI_MST_ABORT && drive_ff;
  wire rd_bad = rd_end && !rd_ok;

  // lock state machine; aborts in full-lock do not unlock
  always_comb begin
    nxt_lock_st = lock_st_ff;
    case (lock_st_ff)
      LK_IDLE: begin
        if (rx_lkrd) begin
          nxt_lock_st = LK_TGT;
        end
      end
      LK_TGT: begin
        if (rd_ok) begin
          nxt_lock_st = LK_FULL;
        end else if (rd_bad) begin
          nxt_lock_st = LK_IDLE;
        end
      end
      LK_FULL: begin
        if (unlock_take) begin
          nxt_lock_st = LK_IDLE;
        end
      end
      default: begin
        nxt_lock_st = LK_IDLE;
      end
    endcase
  end

  // lock pin drive: the locked read itself, then every downstream cycle under full-lock
  wire nxt_drive = (st_tgt && (LK_RD_START || (rd_act_ff && !rd_end)))
    || (st_full && PCI_MST_BUSY && !unlock_take);
  assign BUS_LOCK_PIN_N_O = 1'b0;
  assign BUS_LOCK_PIN_N_OE = drive_ff;

  // lock sequencing flops
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      lock_st_ff <= LK_IDLE;
      rd_pend_ff <= 1'b0;
      rd_act_ff <= 1'b0;
      drive_ff <= 1'b0;
      cpl_err_ff <= 1'b0;
    end else begin
      lock_st_ff <= nxt_lock_st;
      rd_pend_ff <= (st_idle && rx_lkrd) || (rd_pend_ff && !LK_RD_START);
      rd_act_ff <= LK_RD_START || (rd_act_ff && !rd_end);
      drive_ff <= nxt_drive;
      cpl_err_ff <= st_tgt && rd_bad;
    end
  end

  // lock pin synchroniser; only the second stage is read
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
    end else begin
      pin_s1_ff <= BUS_LOCK_PIN_N_I;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // slot power limit capture
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      scale_ff <= SPL_SCALE_RST;
      value_ff <= SPL_VALUE_RST;
    end else if (spl_take) begin
      scale_ff <= RX_SPL_SCALE;
      value_ff <= RX_SPL_VALUE;
    end
  end

  assign LK_CPL_ERR = cpl_err_ff;
  assign LOCK_TGT = st_tgt;
  assign LOCK_FULL = st_full;
  assign SLOT_PWR_SCALE = scale_ff;
  assign SLOT_PWR_VALUE = value_ff;

  // ordering decisions for the queues outside
  btpl_order #(.W(STAMP_W)) u_order (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .enq_posted(ORD_ENQ_POSTED),
    .iss_posted(ORD_ISS_POSTED),
    .cand_class(ORD_CLASS),
    .cand_ro(ORD_RO),
    .cand_stamp(ORD_STAMP_IN),
    .stamp(ORD_STAMP),
    .pass_ok(ORD_PASS_OK)
  );

  // internally generated messages wait out a full lock
  btpl_evmsg u_evmsg (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .int_n(PCI_INT_N),
    .pme_n(PM_EVENT_IN_N),
    .hold(st_full),
    .ready(UP_MSG_READY),
    .valid(UP_MSG_VALID),
    .code(UP_MSG_CODE)
  );

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  // command policy on both pci roles, held against the raw codes
  a_tgt_claim_set: assert property (
    PCI_TGT_CLAIM
    |-> !(PCI_TGT_CMD inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB}))
    else $error("target claimed a forbidden command");

  a_mst_cmd_set: assert property (
    PCI_MST_GO
    |-> !(PCI_MST_CMD inside {4'h0, 4'h4, 4'h5, 4'h8, 4'h9}))
    else $error("master issued a forbidden command");

  a_devid_mabort: assert property (
    PCI_TGT_VALID && PCI_TGT_DEVID_MSG
    |-> PCI_TGT_MABORT && !PCI_TGT_CLAIM)
    else $error("device id message was claimed");

  // link type policy in both directions
  a_tx_types: assert property (
    TX_GO
    |-> !(TX_TYPE inside {TLP_MRDLK, TLP_CFGRD0, TLP_CFGWR0,
      TLP_CFGRD1, TLP_CFGWR1, TLP_MSGD}))
    else $error("forbidden tlp type transmitted");

  a_lkcpl_rx_ur: assert property (
    RX_VALID && (RX_TYPE inside {TLP_CPLLK, TLP_CPLDLK})
    |-> RX_UR)
    else $error("locked completion accepted on receive");

  a_lkcpl_tx_idle: assert property (
    TX_GO && st_idle
    |-> !(TX_TYPE inside {TLP_CPLLK, TLP_CPLDLK}))
    else $error("locked completion sent with no locked read");

  a_rx_one_verdict: assert property (
    RX_VALID
    |-> $onehot({RX_ACCEPT, RX_UR, RX_MALF, RX_DROP}))
    else $error("received tlp without exactly one verdict");

  a_vend1_drop: assert property (
    RX_VALID && st_idle && mc_v1
    |-> RX_DROP)
    else $error("vendor type1 message not dropped");

  // lock controller
  a_lock_entry: assert property (
    st_idle && rx_lkrd
    |=> st_tgt)
    else $error("locked read did not enter target-lock");

  a_tgt_lock_ur: assert property (
    st_tgt && RX_VALID
    |-> RX_UR && !RX_ACCEPT)
    else $error("tlp accepted during target-lock");

  a_tgt_no_retry: assert property (
    st_tgt && PCI_TGT_CLAIM
    |-> !PCI_TGT_RETRY)
    else $error("pci transaction retried during target-lock");

  a_start_idle: assert property (
    LK_RD_START
    |-> DN_AHEAD_IDLE ##1 rd_act_ff)
    else $error("locked read started before queue drained");

  a_abort_nolock: assert property (
    st_tgt && rd_act_ff && PCI_MST_DONE && PCI_MST_ABORT
    |=> st_idle && LK_CPL_ERR ##1 !LK_CPL_ERR)
    else $error("failed locked read did not unlock with error");

  a_full_holds: assert property (
    st_full && !(RX_VALID && RX_TYPE inside {TLP_MSG, TLP_MSGD}
      && RX_MSG_CODE == MC_UNLOCK)
    |=> st_full)
    else $error("left full-lock without unlock message");

  a_full_retry: assert property (
    st_full && PCI_TGT_CLAIM
    |-> PCI_TGT_RETRY)
    else $error("upstream pci not retried under full-lock");

  a_full_tx_hold: assert property (
    st_full && TX_GO
    |-> !(TX_TYPE inside {TLP_MRD, TLP_MWR, TLP_IORD, TLP_IOWR, TLP_MSG}))
    else $error("upstream request released under full-lock");

  a_pin_in_full: assert property (
    st_full && PCI_MST_BUSY && !unlock_take
    |=> BUS_LOCK_PIN_N_OE)
    else $error("lock pin not driven under full-lock");

  // slot power capture
  a_spl_store: assert property (
    spl_take
    |=> SLOT_PWR_VALUE == $past(RX_SPL_VALUE)
      && SLOT_PWR_SCALE == $past(RX_SPL_SCALE))
    else $error("slot power payload not stored");

  // main scenarios
  c_full_lock: cover property (st_tgt ##1 st_full);
  c_unlock: cover property (st_full ##1 st_idle);
  c_abort: cover property (LK_CPL_ERR);
  c_spl_take: cover property (spl_take);
  c_msg_sent: cover property (UP_MSG_VALID && UP_MSG_READY);
endmodule : btpl_core

// ---- core/btpl_evmsg.sv ----
`timescale 1ns/1ps
// turns INTx and PME pin activity into upstream message requests
module btpl_evmsg (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins, active low, asynchronous
  input wire logic [3:0] int_n,
  input wire logic pme_n,
  // message port
  input wire logic hold,
  input wire logic ready,
  output logic valid,
  output logic [7:0] code
);
  import btpl_pkg::*;
  logic [4:0] s1_ff;
  logic [4:0] s2_ff;
  logic [4:0] prev_ff;
  logic [4:0] pend_ff;
  logic out_ff;
  logic [7:0] code_ff;
  logic [4:0] nxt_pend;
  logic [4:0] take;
  wire [4:0] pins = {pme_n, int_n};
  wire load = !out_ff && (pend_ff != 5'h00) && !hold;
  // lowest pending line wins; a later change simply re-arms it
  assign take = pend_ff & (~pend_ff + 5'h01);
  // pend set on change, PME on assertion only; set beats the clear of the same cycle
  genvar i;
  for (i = 0; i < 5; i++) begin : g_line
    wire chg = (i == 4) ? (prev_ff[i] && !s2_ff[i]) : (prev_ff[i] ^ s2_ff[i]);
    assign nxt_pend[i] = chg || (pend_ff[i] && !(load && take[i]));
  end
  // message code for the picked line, from the settled level
  function automatic logic [7:0] pick_code(input logic [4:0] t, input logic [4:0] lvl);
    logic [7:0] c;
    c = MC_PME;
    for (int k = 0; k < 4; k++) begin
      if (t[k]) begin
        c = (lvl[k] ? MC_DEINTX : MC_INTX) + 8'(k);
      end
    end
    return c;
  endfunction : pick_code
  assign valid = out_ff && !hold;
  assign code = code_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_ff <= 5'h1F;
      s2_ff <= 5'h1F;
      prev_ff <= 5'h1F;
      pend_ff <= 5'h00;
      out_ff <= 1'b0;
      code_ff <= 8'h00;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      prev_ff <= s2_ff;
      pend_ff <= nxt_pend;
      out_ff <= load || (out_ff && !(ready && !hold));
      code_ff <= load ? pick_code(take, s2_ff) : code_ff;
    end
  end
  a_hold_msgs: assert property (@(posedge clk) disable iff (!rst_b)
    hold |-> !valid)
    else $error("message released during full lock");
endmodule : btpl_evmsg

// ---- core/btpl_order.sv ----
`timescale 1ns/1ps
// posted-write stamp tracker deciding whether a queued entry may go
module btpl_order #(
  parameter int W = btpl_pkg::STAMP_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // queue events
  input wire logic enq_posted,
  input wire logic iss_posted,
  // candidate
  input wire btpl_pkg::btpl_ord_t cand_class,
  input wire logic cand_ro,
  input wire logic [W-1:0] cand_stamp,
  output logic [W-1:0] stamp,
  output logic pass_ok
);
  import btpl_pkg::*;
  logic [W-1:0] enq_ff;
  logic [W-1:0] iss_ff;
  // modular distances; W must cover the deepest posted backlog
  wire [W-1:0] since = enq_ff - cand_stamp;
  wire [W-1:0] outs = enq_ff - iss_ff;
  wire oldest = (cand_stamp == iss_ff);
  wire clear_ahead = (since >= outs);
  wire ro_pass = (cand_class == ORD_RDCPL) && cand_ro;
  assign stamp = enq_ff;
  assign pass_ok = (cand_class == ORD_POSTED) ? oldest : (ro_pass || clear_ahead);
  // counters only ever advance
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enq_ff <= '0;
      iss_ff <= '0;
    end else begin
      enq_ff <= enq_ff + W'(enq_posted);
      iss_ff <= iss_ff + W'(iss_posted);
    end
  end
  a_posted_fifo: assert property (@(posedge clk) disable iff (!rst_b)
    pass_ok && cand_class == ORD_POSTED |-> cand_stamp == iss_ff)
    else $error("posted passed earlier posted");
  a_cpl_no_ro: assert property (@(posedge clk) disable iff (!rst_b)
    pass_ok && cand_class == ORD_RDCPL && !cand_ro |-> since >= outs)
    else $error("read completion passed posted without RO");
endmodule : btpl_order

// ---- core/btpl_pkg.sv ----
// Behaviour
// - target claims only I/O and memory commands
// - master never issues interrupt-ack or reserved codes
// - accept locked reads, config, MsgD; never transmit
// - locked completions sent only, never accepted
// - INTx level changes become assert/deassert messages
// - PME input assertion becomes PME message
// - slot power limit payload captured into fields
// - device ID messages on PCI master-aborted
// - vendor type1 dropped, vendor type0 UR
// - ignored dropped, error UR, INTx malformed
// - posted never passes earlier posted
// - read completion passes posted only with RO
// - others wait on posted, pass the rest
// - upstream PCI ignores bus lock, stays unlocked
// - lock needs locked read, lock pin, TRDY
// - only unlock message leaves locked condition
// - target-lock: all TLPs UR, PCI still accepted
// - successful locked read completion gives full-lock
// - locked read waits for earlier requests
// - full-lock: retry upstream, UR non-memory, hold
// - under lock every downstream cycle asserts lock
// - failed initial locked read: no lock, error
package btpl_pkg;
  // tlp kinds as seen by this core
  typedef enum logic [3:0] {
    TLP_MRD = 4'h0, TLP_MRDLK = 4'h1, TLP_MWR = 4'h2, TLP_IORD = 4'h3,
    TLP_IOWR = 4'h4, TLP_CFGRD0 = 4'h5, TLP_CFGWR0 = 4'h6, TLP_CFGRD1 = 4'h7,
    TLP_CFGWR1 = 4'h8, TLP_MSG = 4'h9, TLP_MSGD = 4'hA, TLP_CPL = 4'hB,
    TLP_CPLD = 4'hC, TLP_CPLLK = 4'hD, TLP_CPLDLK = 4'hE
  } btpl_tlp_t;
  // lock controller states, one-hot
  typedef enum logic [2:0] {
    LK_IDLE = 3'h1, LK_TGT = 3'h2, LK_FULL = 3'h4
  } btpl_lock_t;
  // ordering classes of a queued transaction
  typedef enum logic [1:0] {
    ORD_POSTED = 2'h0, ORD_NP = 2'h1, ORD_RDCPL = 2'h2, ORD_WRCPL = 2'h3
  } btpl_ord_t;
  // pci command masks, one bit per command code
  localparam logic [15:0] TGT_CMD_MASK = 16'hF0CC;
  localparam logic [15:0] MST_CMD_MASK = 16'hFCCE;
  // message codes
  localparam logic [7:0] MC_UNLOCK = 8'h00;
  localparam logic [7:0] MC_PME = 8'h18;
  localparam logic [7:0] MC_INTX = 8'h20;
  localparam logic [7:0] MC_DEINTX = 8'h24;
  localparam logic [7:0] MC_ERR_COR = 8'h30;
  localparam logic [7:0] MC_ERR_NF = 8'h31;
  localparam logic [7:0] MC_ERR_F = 8'h33;
  localparam logic [7:0] MC_IGN_LO = 8'h40;
  localparam logic [7:0] MC_IGN_HI = 8'h48;
  localparam logic [7:0] MC_SPL = 8'h50;
  localparam logic [7:0] MC_VEND0 = 8'h7E;
  localparam logic [7:0] MC_VEND1 = 8'h7F;
  // reset values and stamp width
  localparam logic [1:0] SPL_SCALE_RST = 2'h0;
  localparam logic [7:0] SPL_VALUE_RST = 8'h00;
  localparam int STAMP_W = 6;
endpackage : btpl_pkg

// ---- dv/btpl_core_tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) chk(g, e)
module btpl_core_tb;
  import btpl_pkg::*;
  // expected claim, master and transmit sets, one bit per code
  localparam logic [15:0] tgt_exp = 16'hF0CC;
  localparam logic [15:0] mst_exp = 16'hFCCE;
  localparam logic [15:0] tx_exp = 16'h1A1D;
  logic ref_clk, rst_b, tgt_valid, tgt_devid, mst_req, dn_idle, rx_valid, tx_valid;
  logic ord_enq, ord_iss, ord_ro, up_ready, pme_n, p_abort;
  logic [3:0] tgt_cmd, mst_cmd, int_n, p_wait;
  btpl_tlp_t rx_type, tx_type;
  btpl_ord_t ord_class;
  logic [7:0] rx_code, spl_value, slot_value, up_code;
  logic [1:0] spl_scale, slot_scale;
  logic [STAMP_W-1:0] ord_stamp_in, ord_stamp;
  logic claim, retry, mabort, mst_go, busy, done, trdy, abort, lk_start, lk_err;
  logic lk_tgt, lk_full, pin_i, pin_o, pin_oe, acc, ur, malf, drop, tx_go, pass_ok, up_valid;
  int bad_count, n_checks, cyc;

  btpl_core uut (
    .REF_CLK(ref_clk), .RST_B(rst_b), .PCI_TGT_VALID(tgt_valid), .PCI_TGT_CMD(tgt_cmd),
    .PCI_TGT_DEVID_MSG(tgt_devid), .PCI_TGT_CLAIM(claim), .PCI_TGT_RETRY(retry),
    .PCI_TGT_MABORT(mabort), .PCI_MST_REQ(mst_req), .PCI_MST_CMD(mst_cmd),
    .PCI_MST_BUSY(busy), .PCI_MST_DONE(done), .PCI_MST_TRDY(trdy), .PCI_MST_ABORT(abort),
    .PCI_MST_GO(mst_go), .DN_AHEAD_IDLE(dn_idle), .LK_RD_START(lk_start),
    .LK_CPL_ERR(lk_err), .LOCK_TGT(lk_tgt), .LOCK_FULL(lk_full), .BUS_LOCK_PIN_N_I(pin_i),
    .BUS_LOCK_PIN_N_O(pin_o), .BUS_LOCK_PIN_N_OE(pin_oe), .RX_VALID(rx_valid),
    .RX_TYPE(rx_type), .RX_MSG_CODE(rx_code), .RX_SPL_SCALE(spl_scale),
    .RX_SPL_VALUE(spl_value), .RX_ACCEPT(acc), .RX_UR(ur), .RX_MALF(malf), .RX_DROP(drop),
    .SLOT_PWR_SCALE(slot_scale), .SLOT_PWR_VALUE(slot_value), .TX_VALID(tx_valid),
    .TX_TYPE(tx_type), .TX_GO(tx_go), .ORD_ENQ_POSTED(ord_enq), .ORD_ISS_POSTED(ord_iss),
    .ORD_CLASS(ord_class), .ORD_RO(ord_ro), .ORD_STAMP_IN(ord_stamp_in),
    .ORD_STAMP(ord_stamp), .ORD_PASS_OK(pass_ok), .PCI_INT_N(int_n),
    .PM_EVENT_IN_N(pme_n), .UP_MSG_READY(up_ready), .UP_MSG_VALID(up_valid),
    .UP_MSG_CODE(up_code));

  btpl_partner far_end (
    .clk(ref_clk), .rst_b(rst_b), .abort_mode(p_abort), .wait_cycles(p_wait),
    .start(lk_start | mst_go), .busy_ff(busy), .done_ff(done), .trdy(trdy), .abort(abort),
    .lock_o(pin_o), .lock_oe(pin_oe), .lock_pin_n(pin_i));

  // clock, 5 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_of_test();
    end
  end

  // inputs move 1 ns after the edge so no race with the core's sampling
  task step;
    @(posedge ref_clk);
    #1;
  endtask : step

  task chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // one received tlp; e is {accept, ur, malformed, drop}
  task rx(input btpl_tlp_t t, input logic [7:0] c, input logic [3:0] e);
    rx_valid = 1'b1;
    rx_type = t;
    rx_code = c;
    #1;
    `CHK({acc, ur, malf, drop}, e);
    step();
    rx_valid = 1'b0;
    step();
  endtask : rx

  // wait for an upstream message, hold off ready a cycle, then take it
  task msg_get(input logic [7:0] c);
    for (int i = 0; i < 12 && up_valid !== 1'b1; i++) step();
    `CHK(up_code, c);
    step();
    `CHK(up_valid, 1'b1);
    up_ready = 1'b1;
    step();
    up_ready = 1'b0;
  endtask : msg_get

  task t_order;
    ord_enq = 1'b1;
    #1;
    `CHK(ord_stamp, 0);
    step();
    step();
    ord_enq = 1'b0;
    ord_class = ORD_POSTED;
    ord_stamp_in = 1;
    ord_ro = 1'b1;
    #1;
    `CHK(ord_stamp, 2);
    `CHK(pass_ok, 1'b0);
    step();
    ord_class = ORD_NP;
    ord_stamp_in = 2;
    ord_ro = 1'b0;
    #1;
    `CHK(pass_ok, 1'b0);
    step();
    ord_class = ORD_RDCPL;
    #1;
    `CHK(pass_ok, 1'b0);
    step();
    ord_ro = 1'b1;
    ord_iss = 1'b1;
    #1;
    `CHK(pass_ok, 1'b1);
    step();
    ord_iss = 1'b0;
    ord_class = ORD_POSTED;
    ord_stamp_in = 1;
    ord_ro = 1'b0;
    #1;
    `CHK(pass_ok, 1'b1);
    step();
    ord_class = ORD_WRCPL;
    ord_stamp_in = 2;
    ord_iss = 1'b1;
    #1;
    `CHK(pass_ok, 1'b0);
    step();
    ord_iss = 1'b0;
    #1;
    `CHK(pass_ok, 1'b1);
    step();
    ord_class = ORD_RDCPL;
    #1;
    `CHK(pass_ok, 1'b1);
    step();
  endtask : t_order

  task t_pci;
    for (int i = 0; i < 16; i++) begin
      tgt_valid = 1'b1;
      tgt_cmd = i[3:0];
      mst_req = 1'b1;
      mst_cmd = i[3:0];
      #1;
      `CHK(claim, tgt_exp[i]);
      `CHK(mabort, !tgt_exp[i]);
      `CHK(mst_go, mst_exp[i]);
      step();
    end
    mst_req = 1'b0;
    tgt_cmd = 4'h7;
    tgt_devid = 1'b1;
    #1;
    `CHK({claim, mabort}, 2'b01);
    step();
    tgt_valid = 1'b0;
    tgt_devid = 1'b0;
    repeat (8) step();
  endtask : t_pci

  task t_rx;
    rx(TLP_MSG, MC_VEND1, 4'b0001);
    rx(TLP_MSGD, MC_VEND0, 4'b0100);
    rx(TLP_MSG, MC_IGN_LO, 4'b0001);
    rx(TLP_MSG, MC_IGN_HI, 4'b0001);
    rx(TLP_MSG, MC_ERR_COR, 4'b0100);
    rx(TLP_MSG, MC_ERR_NF, 4'b0100);
    rx(TLP_MSG, MC_ERR_F, 4'b0100);
    rx(TLP_MSG, MC_INTX, 4'b0010);
    rx(TLP_MSG, MC_DEINTX, 4'b0010);
    rx(TLP_CPLLK, 8'h00, 4'b0100);
    rx(TLP_CPLDLK, 8'h00, 4'b0100);
    rx(TLP_CFGWR1, 8'h00, 4'b1000);
    spl_scale = 2'h2;
    spl_value = 8'hA5;
    rx(TLP_MSGD, MC_SPL, 4'b1000);
    `CHK({slot_scale, slot_value}, 10'h2A5);
  endtask : t_rx

  task t_tx;
    for (int i = 0; i < 15; i++) begin
      tx_valid = 1'b1;
      tx_type = btpl_tlp_t'(i[3:0]);
      #1;
      `CHK(tx_go, tx_exp[i]);
      step();
    end
    tx_valid = 1'b0;
  endtask : t_tx

  task t_msg;
    int_n = 4'hD;
    msg_get(MC_INTX + 8'h01);
    int_n = 4'hF;
    msg_get(MC_DEINTX + 8'h01);
    pme_n = 1'b0;
    msg_get(MC_PME);
    pme_n = 1'b1;
    repeat (6) step();
  endtask : t_msg

  task t_lock_ok;
    rx(TLP_MRDLK, 8'h00, 4'b1000);
    `CHK({lk_tgt, lk_full, lk_start}, 3'b100);
    rx(TLP_MRD, 8'h00, 4'b0100);
    rx(TLP_MSG, MC_UNLOCK, 4'b0100);
    tgt_valid = 1'b1;
    tx_valid = 1'b1;
    tx_type = TLP_CPLDLK;
    #1;
    `CHK({claim, retry, lk_start}, 3'b100);
    `CHK(tx_go, 1'b1);
    step();
    tgt_valid = 1'b0;
    tx_valid = 1'b0;
    dn_idle = 1'b1;
    #1;
    `CHK(lk_start, 1'b1);
    step();
    dn_idle = 1'b0;
    #1;
    `CHK(pin_oe, 1'b1);
    `CHK(pin_o, 1'b0);
    for (int i = 0; i < 20 && lk_full !== 1'b1; i++) step();
    `CHK({lk_full, lk_tgt}, 2'b10);
    tgt_valid = 1'b1;
    tgt_cmd = 4'h6;
    tx_valid = 1'b1;
    tx_type = TLP_MWR;
    int_n = 4'hB;
    #1;
    `CHK({retry, tx_go}, 2'b10);
    step();
    tx_type = TLP_CPLD;
    #1;
    `CHK(tx_go, 1'b1);
    step();
    tgt_valid = 1'b0;
    tx_valid = 1'b0;
    rx(TLP_IORD, 8'h00, 4'b0100);
    rx(TLP_CFGRD0, 8'h00, 4'b0100);
    rx(TLP_MWR, 8'h00, 4'b1000);
    rx(TLP_CPLD, 8'h00, 4'b1000);
    `CHK(up_valid, 1'b0);
    // an aborted downstream cycle under lock must not drop the lock
    p_abort = 1'b1;
    mst_req = 1'b1;
    mst_cmd = 4'h7;
    step();
    mst_req = 1'b0;
    step();
    `CHK(pin_oe, 1'b1);
    for (int i = 0; i < 20 && done !== 1'b1; i++) step();
    step();
    `CHK(lk_full, 1'b1);
    p_abort = 1'b0;
    rx(TLP_MSG, MC_UNLOCK, 4'b1000);
    `CHK({lk_full, lk_tgt}, 2'b00);
    msg_get(MC_INTX + 8'h02);
    int_n = 4'hF;
    msg_get(MC_DEINTX + 8'h02);
  endtask : t_lock_ok

  task t_lock_fail;
    p_abort = 1'b1;
    dn_idle = 1'b1;
    rx(TLP_MRDLK, 8'h00, 4'b1000);
    for (int i = 0; i < 20 && lk_err !== 1'b1; i++) step();
    `CHK({lk_err, lk_tgt, lk_full}, 3'b100);
    step();
    `CHK(lk_err, 1'b0);
  endtask : t_lock_fail

  // reset, then the scenarios in turn
  initial begin
    {rst_b, tgt_valid, tgt_devid, mst_req, dn_idle, rx_valid, tx_valid} = 7'h00;
    {ord_enq, ord_iss, ord_ro, up_ready, p_abort} = 5'h00;
    {tgt_cmd, mst_cmd, rx_code, spl_scale, spl_value} = 26'h0;
    rx_type = TLP_MRD;
    tx_type = TLP_MRD;
    ord_class = ORD_POSTED;
    ord_stamp_in = 6'h00;
    int_n = 4'hF;
    pme_n = 1'b1;
    p_wait = 4'h3;
    repeat (8) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    `CHK({slot_scale, slot_value}, 10'h000);
    `CHK({lk_tgt, lk_full, pin_oe, up_valid}, 4'h0);
    t_order();
    t_pci();
    t_rx();
    t_tx();
    t_msg();
    t_lock_ok();
    t_lock_fail();
    end_of_test();
  end
endmodule : btpl_core_tb

// ---- dv/btpl_partner.sv ----
`timescale 1ns/1ps
// far side model: the pci master engine and the shared bus lock line
module btpl_partner (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // behaviour chosen by the bench
  input wire logic abort_mode,
  input wire logic [3:0] wait_cycles,
  // cycle request and its answer
  input wire logic start,
  output logic busy_ff,
  output logic done_ff,
  output logic trdy,
  output logic abort,
  // lock line, split pin of the core
  input wire logic lock_o,
  input wire logic lock_oe,
  output logic lock_pin_n
);
  logic [3:0] cnt_ff;

  // one cycle at a time; a start seen while busy is dropped, like a real engine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      cnt_ff <= 4'h0;
    end else if (done_ff) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (busy_ff) begin
      if (cnt_ff == 4'h0) begin
        done_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end else if (start) begin
      busy_ff <= 1'b1;
      cnt_ff <= wait_cycles;
    end
  end

  // the target answers with trdy, or aborts when the bench asks for it
  assign trdy = done_ff & !abort_mode;
  assign abort = done_ff & abort_mode;
  // pulled up: nobody else holds the lock, so released means high
  assign lock_pin_n = lock_oe ? lock_o : 1'b1;
endmodule : btpl_partner
